// file: logic/psrss_seq.sv
module psrss_seq #(
	parameter int NX = psrss_pkg::NUM_X,
	parameter int NY = psrss_pkg::NUM_Y
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rstn,
	input wire logic en,
	// external terminals
	input wire logic runStopShort,
	input wire logic [NX-1:0] inPins,
	output logic [NY-1:0] outPins,
	output logic runLed,
	// controller settings and remote command
	input wire logic remoteStop,
	input wire logic restoreMode,
	input wire logic [psrss_pkg::CAP_W-1:0] progCapacity,
	// program memory
	output logic [psrss_pkg::STEP_W-1:0] progAddr,
	input wire logic [psrss_pkg::INSN_W-1:0] progData,
	// execution unit
	output logic stepStrobe,
	input wire logic yWrEn,
	input wire logic [$clog2(NY)-1:0] yWrIdx,
	input wire logic yWrVal,
	output logic [NX-1:0] inImage,
	// data memory and timer unit control, self-check fault flag
	output logic memClear,
	output logic dataWrAllow,
	output logic tcUpdate,
	output logic diagFault
);
	import psrss_pkg::*;

	psrss_state_t state, next_state;
	logic shortMeta, shortSync;
	logic [NX-1:0] inMeta, inSync;
	logic [STEP_W-1:0] next_progAddr;
	logic [INIT_CNT_W-1:0] initCnt, next_initCnt;
	logic [NY-1:0] yImage, next_yImage, savedY, next_savedY, next_outPins, yHit;
	logic [NX-1:0] next_inImage;
	logic next_runLed, runReq, isEnd, lastStep, diagStart, diagBusy, diagDone, diagPass;
	logic [CAP_W-1:0] capEff;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			shortMeta <= 1'b0;
			shortSync <= 1'b0;
			inMeta <= '0;
			inSync <= '0;
		end else if (en) begin
			shortMeta <= runStopShort;
			shortSync <= shortMeta;
			inMeta <= inPins;
			inSync <= inMeta;
		end
	end

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	// remote stop is a level from this clock domain; it wins over a short
	assign runReq = shortSync && !remoteStop;
	// a single main program: no other program type to dispatch to
	assign isEnd = (progData[OP_MSB:OP_LSB] == OP_END) ||
		(progData[OP_MSB:OP_LSB] == OP_FINAL_END_INSTRUCTION);
	// capacity above the store size is clamped so fetch stays in range
	assign capEff = (progCapacity > CAP_W'(MAX_STEPS)) ? CAP_W'(MAX_STEPS) : progCapacity;
	assign lastStep = ({1'b0, progAddr} + CAP_W'(1)) >= capEff;
	assign stepStrobe = (state == S_EXEC);
	assign memClear = (state == S_INIT_CLR);
	assign dataWrAllow = (state == S_EXEC);
	assign tcUpdate = (state == S_END_PROC);
	assign diagStart = (state == S_INIT_DIAG) || (state == S_END_DIAG);

	// one write decoder per output bit
	genvar gi;
	generate
		for (gi = 0; gi < NY; gi++) begin : gYHit
			assign yHit[gi] = yWrEn && (yWrIdx == ($clog2(NY))'(gi));
		end
	endgenerate

	// ------------------------------------------------------------
	// sequencer next state
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_progAddr = progAddr;
		next_initCnt = initCnt;
		next_yImage = yImage;
		next_savedY = savedY;
		next_outPins = outPins;
		next_inImage = inImage;
		case (state)
			S_INIT_CLR: begin
				// images already zero from reset; count out the memory clear
				next_initCnt = initCnt + INIT_CNT_W'(1);
				if (initCnt == INIT_CNT_W'(INIT_CLR_CYCLES - 1)) begin
					next_state = S_INIT_DIAG;
				end
			end
			S_INIT_DIAG: begin
				if (diagDone) begin
					if (!diagPass) begin
						next_state = S_FAULT;
					end else if (runReq) begin
						next_state = S_REFRESH;
					end else begin
						next_state = S_STOP;
					end
				end
			end
			S_STOP: begin
				// refresh keeps running so a tool can watch and test I/O
				next_inImage = inSync;
				next_yImage = yImage | yHit;
				next_yImage = next_yImage & ~(yHit & {NY{~yWrVal}});
				next_outPins = next_yImage;
				if (runReq) begin
					next_state = S_REFRESH;
					// restore mode clear leaves outputs off until the program sets them
					next_yImage = restoreMode ? savedY : '0;
				end
			end
			S_REFRESH: begin
				next_inImage = inSync;
				next_outPins = yImage;
				next_progAddr = '0;
				next_state = S_EXEC;
			end
			S_EXEC: begin
				if (!runReq) begin
					// save before clearing: both use this cycle's image
					next_savedY = yImage;
					next_yImage = '0;
					next_outPins = '0;
					next_state = S_STOP;
				end else begin
					next_yImage = yImage | yHit;
					next_yImage = next_yImage & ~(yHit & {NY{~yWrVal}});
					if (isEnd || lastStep) begin
						next_state = S_END_PROC;
					end else begin
						next_progAddr = progAddr + STEP_W'(1);
					end
				end
			end
			S_END_PROC: begin
				next_state = S_END_DIAG;
			end
			S_END_DIAG: begin
				if (diagDone) begin
					if (!diagPass) begin
						next_state = S_FAULT;
					end else if (runReq) begin
						next_state = S_REFRESH;
					end else begin
						next_savedY = yImage;
						next_yImage = '0;
						next_outPins = '0;
						next_state = S_STOP;
					end
				end
			end
			S_FAULT: begin
				// halted until reset; outputs held off
				next_outPins = '0;
				next_inImage = inSync;
			end
			default: begin
				next_state = S_FAULT;
			end
		endcase
		next_runLed = (next_state == S_REFRESH) || (next_state == S_EXEC) ||
			(next_state == S_END_PROC) || (next_state == S_END_DIAG);
	end

	// inputs and outputs start cleared; no pin value is loaded at reset
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= S_INIT_CLR;
			progAddr <= '0;
			initCnt <= '0;
			yImage <= '0;
			savedY <= '0;
			outPins <= '0;
			inImage <= '0;
			runLed <= 1'b0;
		end else if (en) begin
			state <= next_state;
			progAddr <= next_progAddr;
			initCnt <= next_initCnt;
			yImage <= next_yImage;
			savedY <= next_savedY;
			outPins <= next_outPins;
			inImage <= next_inImage;
			runLed <= next_runLed;
		end
	end

	// ------------------------------------------------------------
	// self-diagnostic unit
	// ------------------------------------------------------------
	psrss_diag uDiag (
		.clk(clk),
		.rstn(rstn),
		.en(en),
		.start(diagStart),
		.capacity(progCapacity),
		.busy(diagBusy),
		.done(diagDone),
		.pass(diagPass),
		.fault(diagFault)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic initDone;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			initDone <= 1'b0;
		end else if (en && state != S_INIT_CLR) begin
			initDone <= 1'b1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn || !en);

	init_once_a: assert property (initDone |-> !memClear)
		else $error("memory clear after initial processing");
	init_clear_a: assert property (memClear |-> (outPins == '0 && !stepStrobe))
		else $error("outputs or steps active during clear");
	init_diag_a: assert property ($fell(memClear) |-> ##[0:2] diagBusy)
		else $error("no self-check after clear");
	step_zero_a: assert property ($rose(stepStrobe) |-> progAddr == '0)
		else $error("scan did not begin at step 0");
	step_order_a: assert property (stepStrobe ##1 stepStrobe |-> progAddr == $past(progAddr) + 1'b1)
		else $error("steps not in order");
	end_proc_a: assert property ((stepStrobe && isEnd && runReq) |=> tcUpdate ##1 !stepStrobe)
		else $error("end not followed by timer update");
	end_return_a: assert property (tcUpdate |-> ##[3:5] ((stepStrobe && progAddr == '0) || !runLed))
		else $error("no return to step 0 after end processing");
	run_led_a: assert property (stepStrobe |-> runLed)
		else $error("executing without run indicator");
	stop_entry_a: assert property ((stepStrobe && !runReq) |=> (!runLed && outPins == '0 && !stepStrobe))
		else $error("stop not entered");
	stop_save_a: assert property ((stepStrobe && !runReq) |=> (savedY == $past(yImage) && yImage == '0))
		else $error("outputs not saved and cleared at stop");
	run_restore_a: assert property ((state == S_STOP && runReq && restoreMode) |=> yImage == $past(savedY))
		else $error("saved outputs not restored");
	stop_hold_a: assert property (!runLed |-> !dataWrAllow)
		else $error("data memory writable in stop");
	stop_refresh_a: assert property ((state == S_STOP) |=> inImage == $past(inSync))
		else $error("input refresh stalled in stop");
	cap_limit_a: assert property (stepStrobe |-> ({1'b0, progAddr} < capEff))
		else $error("step beyond program capacity");
	init_mode_a: assert property ((state == S_INIT_DIAG && diagDone && diagPass) |=> runLed == $past(runReq))
		else $error("wrong mode after initial processing");

	scan_done_c: cover property (tcUpdate ##[1:5] (stepStrobe && progAddr == '0));
	stop_entry_c: cover property (stepStrobe && !runReq);
	restore_c: cover property (state == S_STOP && runReq && restoreMode);
	fault_c: cover property ($rose(diagFault));
endmodule : psrss_seq

// file: logic/psrss_pkg.sv
package psrss_pkg;
	// ------------------------------------------------------------
	// program store and instruction layout
	// ------------------------------------------------------------
	localparam int MAX_STEPS = 1024;
	localparam int STEP_W = 10;
	localparam int CAP_W = 11;
	localparam int INSN_W = 16;
	localparam int OP_MSB = 15;
	localparam int OP_LSB = 8;
	localparam logic [7:0] OP_END = 8'hf0;
	localparam logic [7:0] OP_FINAL_END_INSTRUCTION = 8'hf1;

	// ------------------------------------------------------------
	// terminal image sizes and timing
	// ------------------------------------------------------------
	localparam int NUM_X = 16;
	localparam int NUM_Y = 16;
	localparam int INIT_CLR_CYCLES = 8;
	localparam int INIT_CNT_W = 4;

	// ------------------------------------------------------------
	// operation circuit self-test pattern
	// ------------------------------------------------------------
	localparam logic [7:0] DIAG_A = 8'h5a;
	localparam logic [7:0] DIAG_B = 8'ha5;
	localparam logic [7:0] DIAG_SUM = 8'hff;

	// ------------------------------------------------------------
	// sequencer states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		S_INIT_CLR,
		S_INIT_DIAG,
		S_STOP,
		S_REFRESH,
		S_EXEC,
		S_END_PROC,
		S_END_DIAG,
		S_FAULT
	} psrss_state_t;
endpackage : psrss_pkg

// file: logic/psrss_diag.sv
module psrss_diag (
	// clock, reset and enable
	input wire logic clk,
	input wire logic rstn,
	input wire logic en,
	// request and configured capacity
	input wire logic start,
	input wire logic [psrss_pkg::CAP_W-1:0] capacity,
	// result
	output logic busy,
	output logic done,
	output logic pass,
	output logic fault
);
	import psrss_pkg::*;

	logic [7:0] sum;
	logic capOk;
	logic next_busy, next_done, next_pass, next_fault, next_capOk;
	logic [7:0] next_sum;

	// ------------------------------------------------------------
	// two-cycle check: launch, then compare
	// ------------------------------------------------------------
	// the adder result goes through a flop so the check exercises a real path
	always_comb begin
		next_busy = 1'b0;
		next_done = 1'b0;
		next_pass = pass;
		next_fault = fault;
		next_sum = sum;
		next_capOk = capOk;
		if (busy) begin
			next_done = 1'b1;
			next_pass = capOk && (sum == DIAG_SUM);
			next_fault = fault | ~next_pass; // sticky until reset
		end else if (start && !done) begin
			next_busy = 1'b1;
			next_sum = DIAG_A + DIAG_B;
			next_capOk = (capacity != '0) && (capacity <= CAP_W'(MAX_STEPS));
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			busy <= 1'b0;
			done <= 1'b0;
			pass <= 1'b0;
			fault <= 1'b0;
			sum <= 8'h00;
			capOk <= 1'b0;
		end else if (en) begin
			busy <= next_busy;
			done <= next_done;
			pass <= next_pass;
			fault <= next_fault;
			sum <= next_sum;
			capOk <= next_capOk;
		end
	end
endmodule : psrss_diag

// file: test/psrss_prog_mem.sv
module psrss_prog_mem (
	// step address from the sequencer
	input wire logic [psrss_pkg::STEP_W-1:0] progAddr,
	output logic [psrss_pkg::INSN_W-1:0] progData,
	// program shape chosen by the bench
	input wire logic [psrss_pkg::STEP_W-1:0] endStep,
	input wire logic [7:0] endOp
);
	import psrss_pkg::*;

	// ------------------------------------------------------------
	// single main program, same-cycle read
	// ------------------------------------------------------------
	// filler varies with the address so a stale fetch does not look valid
	assign progData = (progAddr == endStep) ? {endOp, 8'h00} : {8'h00, progAddr[7:0]};
endmodule : psrss_prog_mem

// file: test/plc_scan_run_stop_sequencer_tb.sv
module plc_scan_run_stop_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import psrss_pkg::*;

	logic clk, rstn, en, runStopShort, remoteStop, restoreMode, yWrEn, yWrVal;
	logic runLed, stepStrobe, memClear, dataWrAllow, tcUpdate, diagFault;
	logic [NUM_X-1:0] inPins, inImage;
	logic [NUM_Y-1:0] outPins;
	logic [CAP_W-1:0] progCapacity;
	logic [STEP_W-1:0] progAddr, endStep;
	logic [INSN_W-1:0] progData;
	logic [3:0] yWrIdx;
	logic [7:0] endOp;
	int miscompares, samples_checked, n;

	psrss_seq #(.NX(NUM_X), .NY(NUM_Y)) i_dut (.clk(clk), .rstn(rstn), .en(en),
		.runStopShort(runStopShort), .inPins(inPins), .outPins(outPins), .runLed(runLed),
		.remoteStop(remoteStop), .restoreMode(restoreMode), .progCapacity(progCapacity),
		.progAddr(progAddr), .progData(progData), .stepStrobe(stepStrobe), .yWrEn(yWrEn),
		.yWrIdx(yWrIdx), .yWrVal(yWrVal), .inImage(inImage), .memClear(memClear),
		.dataWrAllow(dataWrAllow), .tcUpdate(tcUpdate), .diagFault(diagFault));

	psrss_prog_mem i_mem (.progAddr(progAddr), .progData(progData), .endStep(endStep),
		.endOp(endOp));

	// ------------------------------------------------------------
	// clock and shared tasks
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic give_verdict;
		$display("checked %0d values, %0d wrong", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : give_verdict

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// a bounded wait that ran out counts as a mismatch and ends the run
	task automatic give_up(input string what);
		miscompares++;
		$display("wrong value %s expected progress seen timeout", what);
		give_verdict();
	endtask : give_up

	// inputs move only at the falling edge, away from sampling
	task automatic tick(input int k);
		repeat (k) @(negedge clk);
	endtask : tick

	// bounded wait; a hang goes straight to the verdict
	task automatic wait_led(input logic v);
		for (n = 0; n < 60 && runLed !== v; n++) tick(1);
		check("runLed", runLed, v);
		if (runLed !== v) give_verdict();
	endtask : wait_led

	task automatic write_y(input logic [3:0] idx, input logic v);
		yWrEn = 1'b1;
		yWrIdx = idx;
		yWrVal = v;
		tick(1);
		yWrEn = 1'b0;
	endtask : write_y

	// one scan from step 0 to last, then end processing and restart
	task automatic scan_check(input int last);
		int t;
		t = 0;
		for (n = 0; n < 40 && !(stepStrobe === 1'b1 && progAddr === '0); n++) tick(1);
		if (n == 40) give_up("scan start");
		for (int i = 0; i <= last; i++) begin
			check("progAddr", progAddr, i);
			check("stepStrobe", stepStrobe, 1);
			check("dataWrAllow", dataWrAllow, 1);
			tick(1);
		end
		for (n = 0; n < 12 && stepStrobe !== 1'b1; n++) begin
			t += (tcUpdate === 1'b1);
			tick(1);
		end
		if (n == 12) give_up("scan restart");
		check("tcUpdate pulses", t, 1);
		check("restart step", progAddr, 0);
		check("restart strobe", stepStrobe, 1);
	endtask : scan_check

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic test_reset;
		int c;
		rstn = 1'b0;
		tick(4);
		check("memClear in reset", memClear, 1);
		check("outPins in reset", outPins, 0);
		check("runLed in reset", runLed, 0);
		rstn = 1'b1;
		c = 0;
		for (n = 0; n < 20 && memClear === 1'b1; n++) begin
			c += (stepStrobe === 1'b1) ? 100 : 1;
			tick(1);
		end
		if (n == 20) give_up("init clear");
		check("init clear cycles", c, INIT_CLR_CYCLES);
		check("diagFault", diagFault, 0);
		wait_led(runStopShort);
		$display("reset test done");
	endtask : test_reset

	task automatic test_run;
		scan_check(2);
		write_y(4'h3, 1'b1);
		scan_check(2);
		check("outPins refreshed", outPins, 16'h0008);
		$display("run test done");
	endtask : test_run

	task automatic test_stop;
		runStopShort = 1'b0;
		wait_led(1'b0);
		check("outPins at stop", outPins, 0);
		check("stepStrobe at stop", stepStrobe, 0);
		check("dataWrAllow at stop", dataWrAllow, 0);
		inPins = 16'h00a5;
		tick(4);
		check("inImage in stop", inImage, 16'h00a5);
		write_y(4'h5, 1'b1);
		tick(2);
		check("outPins test write", outPins, 16'h0020);
		write_y(4'h5, 1'b0);
		tick(2);
		$display("stop test done");
	endtask : test_stop

	task automatic test_restore;
		restoreMode = 1'b1;
		runStopShort = 1'b1;
		wait_led(1'b1);
		scan_check(2);
		check("outPins restored", outPins, 16'h0008);
		remoteStop = 1'b1;
		wait_led(1'b0);
		check("outPins remote stop", outPins, 0);
		restoreMode = 1'b0;
		remoteStop = 1'b0;
		wait_led(1'b1);
		scan_check(2);
		check("outPins not restored", outPins, 0);
		$display("restore test done");
	endtask : test_restore

	task automatic test_program;
		endOp = OP_FINAL_END_INSTRUCTION;
		endStep = 10'h004;
		scan_check(4);
		progCapacity = 11'h003;
		endStep = 10'h00a;
		// a lit output makes the off-on-fault check below meaningful
		write_y(4'h1, 1'b1);
		scan_check(2);
		check("outPins before fault", outPins, 16'h0002);
		// bad capacity goes in during end processing, so no step runs with it
		for (n = 0; n < 20 && tcUpdate !== 1'b1; n++) tick(1);
		if (n == 20) give_up("end processing");
		progCapacity = 11'h000;
		for (n = 0; n < 40 && diagFault !== 1'b1; n++) tick(1);
		if (n == 40) give_up("self-check fault");
		check("diagFault", diagFault, 1);
		// fault flag leads the halt state by one edge, outputs by two
		tick(2);
		check("runLed on fault", runLed, 0);
		check("outPins on fault", outPins, 0);
		progCapacity = 11'h400;
		$display("program test done");
	endtask : test_program

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		miscompares = 0;
		samples_checked = 0;
		rstn = 1'b0;
		en = 1'b1;
		runStopShort = 1'b1;
		remoteStop = 1'b0;
		restoreMode = 1'b0;
		yWrEn = 1'b0;
		yWrIdx = 4'h0;
		yWrVal = 1'b0;
		inPins = 16'h0000;
		progCapacity = 11'h400;
		endStep = 10'h002;
		endOp = OP_END;
		test_reset();
		test_run();
		test_stop();
		test_restore();
		test_program();
		// second reset must clear the sticky fault
		endOp = OP_END;
		endStep = 10'h002;
		test_reset();
		give_verdict();
	end
endmodule : plc_scan_run_stop_sequencer_tb
